//--- src/rlsb_pkg.sv
package rlsb_pkg;

  // Register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] RLS_TWO_ADDR = 12'h091;
  localparam logic [11:0] RLS_THREE_ADDR = 12'h092;
  localparam logic [11:0] RLS_FOUR_ADDR = 12'h093;
  localparam logic [7:0] RLS_RESET = 8'h00;
  localparam logic [7:0] RLS_TWO_INT_MASK = 8'h0F;

  // Field positions, second register (E1)
  localparam int B2_CRC_RESYNC = 6;
  localparam int B2_CAS_RESYNC = 5;
  localparam int B2_FAS_RESYNC = 4;
  localparam int B2_SIG_ONES = 3;
  localparam int B2_SIG_ZEROS = 2;
  localparam int B2_CRC4_MF = 1;
  localparam int B2_ALIGN = 0;
  // Field positions, third register
  localparam int B3_CLK_CLEAR = 7;
  localparam int B3_SPARE_CLEAR = 6;
  localparam int B3_LOOPDN_CLEAR = 5;
  localparam int B3_LOOPUP_CLEAR = 4;
  localparam int B3_V52_CLEAR = 5;
  localparam int B3_DMA_CLEAR = 4;
  localparam int B3_CLK_DETECT = 3;
  localparam int B3_SPARE_DETECT = 2;
  localparam int B3_LOOPDN_DETECT = 1;
  localparam int B3_LOOPUP_DETECT = 0;
  localparam int B3_V52_DETECT = 1;
  localparam int B3_DMA_DETECT = 0;
  // Field positions, fourth register
  localparam int B4_FULL = 7;
  localparam int B4_EMPTY = 6;
  localparam int B4_SLIP = 5;
  localparam int B4_SIG_CHANGE = 3;
  localparam int B4_ONE_SEC = 2;
  localparam int B4_TIMER = 1;
  localparam int B4_MF = 0;

  // Error counter configuration field
  localparam int CFG_SHORT_INTERVAL = 0;

  // Detection figures
  localparam int CRC_WINDOW = 1000;
  localparam int CRC_ERR_LIMIT = 915;
  localparam int FAS_ERR_RUN = 3;
  localparam int SIG_ONES_FRAMES = 16;
  localparam int SIG_ONES_MAX_ZEROS = 3;
  localparam int DMA_BIT = 2;
  localparam int D4_MF_FRAMES = 12;
  localparam int ESF_MF_FRAMES = 24;
  localparam int E1_MF_FRAMES = 16;

  // Timing: channel times, clock and line rates
  localparam int CLK_PERIOD_NS = 10;
  localparam int CHAN_TIME_T1_NS = 5181;
  localparam int CHAN_TIME_E1_NS = 3906;
  localparam int CHAN_CYC_T1 = (CHAN_TIME_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHAN_CYC_E1 = (CHAN_TIME_E1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINE_RATE_T1_KHZ = 1544;
  localparam int LINE_RATE_E1_KHZ = 2048;
  localparam int ONE_SECOND_MS = 1000;
  localparam int SHORT_T1_US = 42000;
  localparam int SHORT_E1_US = 62500;
  localparam int SEC_EDGES_T1 = LINE_RATE_T1_KHZ * ONE_SECOND_MS;
  localparam int SEC_EDGES_E1 = LINE_RATE_E1_KHZ * ONE_SECOND_MS;
  localparam int SHORT_EDGES_T1 = LINE_RATE_T1_KHZ * SHORT_T1_US / 1000;
  localparam int SHORT_EDGES_E1 = LINE_RATE_E1_KHZ * SHORT_E1_US / 1000;

  // Per-frame report from the framer
  typedef struct packed {
    logic strobe;
    logic mf_start;
    logic [7:0] ts16;
  } rlsb_frame_t;

  // Checked alignment or code word
  typedef struct packed {
    logic valid;
    logic err;
  } rlsb_word_t;

  // Live conditions from the code detectors
  typedef struct packed {
    logic spare;
    logic loopdown;
    logic loopup;
    logic v52;
  } rlsb_cond_t;

  typedef struct packed {
    logic [7:0] bits;
  } rlsb_latch_state_t;

  typedef struct packed {
    logic rclk_s1;
    logic rclk_s2;
    logic rclk_s3;
    logic [9:0] idle_cnt;
    logic clock_loss;
    logic [20:0] sec_cnt;
    logic [20:0] upd_cnt;
    logic [4:0] frame_cnt;
    logic [9:0] crc_words;
    logic [9:0] crc_errs;
    logic cas_err_prev;
    logic [1:0] fas_run;
    logic [3:0] ones_frames;
    logic [1:0] ones_zeros;
    logic zeros_all;
    logic dma_prev;
    logic dma_alarm;
    rlsb_cond_t cond_prev;
    logic [7:0] rdata;
    logic rvalid;
  } rlsb_state_t;

endpackage : rlsb_pkg

//--- src/rlsb_latch_byte.sv
`timescale 1ns/1ps
module rlsb_latch_byte (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Events and read clear
  input wire logic [7:0] set_i,
  input wire logic clear_i,
  // Latched bits
  output logic [7:0] bits_o
);

  rlsb_pkg::rlsb_latch_state_t state_reg;
  rlsb_pkg::rlsb_latch_state_t state_next;
  logic [7:0] bit_next;

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      // Set wins over a clear in the same cycle
      assign bit_next[i] = set_i[i] | (state_reg.bits[i] & ~clear_i);
    end
  endgenerate

  always_comb
  begin
    state_next = state_reg;
    state_next.bits = bit_next;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      state_reg <= '{bits: rlsb_pkg::RLS_RESET};
    else if (ce_i)
      state_reg <= state_next;
  end

  assign bits_o = state_reg.bits;

endmodule : rlsb_latch_byte

//--- src/rlsb_status_bank.sv
`timescale 1ns/1ps
module rlsb_status_bank #(
  parameter int SEC_EDGES_T1 = rlsb_pkg::SEC_EDGES_T1,
  parameter int SEC_EDGES_E1 = rlsb_pkg::SEC_EDGES_E1,
  parameter int SHORT_EDGES_T1 = rlsb_pkg::SHORT_EDGES_T1,
  parameter int SHORT_EDGES_E1 = rlsb_pkg::SHORT_EDGES_E1
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Configuration
  input wire logic mode_t1_i,
  input wire logic esf_i,
  input wire logic crc4_en_i,
  input wire logic [7:0] error_counter_config_i,
  input wire logic [31:0] sig_change_enable_i,
  // Receive line clock pin
  input wire logic rclk_i,
  // Framer reports
  input wire rlsb_pkg::rlsb_frame_t frame_i,
  input wire rlsb_pkg::rlsb_word_t crc_word_i,
  input wire rlsb_pkg::rlsb_word_t cas_word_i,
  input wire rlsb_pkg::rlsb_word_t fas_word_i,
  input wire logic crc4_mf_boundary_i,
  input wire rlsb_pkg::rlsb_cond_t cond_i,
  input wire logic [31:0] sig_changed_i,
  input wire logic elastic_full_i,
  input wire logic elastic_empty_i,
  input wire logic manual_latch_i,
  // Microprocessor read port
  input wire logic rd_i,
  input wire logic [rlsb_pkg::ADDR_W-1:0] addr_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // Status
  output logic rx_clock_loss_o,
  output logic int_pending_o
);

  rlsb_pkg::rlsb_state_t st_reg;
  rlsb_pkg::rlsb_state_t st_next;

  logic [7:0] set_two;
  logic [7:0] set_three;
  logic [7:0] set_four;
  logic [7:0] lat_two;
  logic [7:0] lat_three;
  logic [7:0] lat_four;
  logic clr_two;
  logic clr_three;
  logic clr_four;

  // Event strobes formed in the combinational process
  logic crc_resync_event;
  logic cas_resync_event;
  logic fas_resync_event;
  logic sig_all_ones_event;
  logic sig_all_zeros_event;
  logic crc4_multiframe_event;
  logic align_frame_event;
  logic rx_multiframe_event;
  logic one_second_event;
  logic timer_event;

  logic [9:0] idle_limit;
  logic [20:0] sec_last;
  logic [20:0] short_last;
  logic [4:0] mf_last;
  logic [4:0] frame_pos;
  logic rclk_edge;
  logic rclk_rise;
  logic [3:0] zero_count;

  always_comb
  begin
    st_next = st_reg;
    crc_resync_event = 1'b0;
    cas_resync_event = 1'b0;
    fas_resync_event = 1'b0;
    sig_all_ones_event = 1'b0;
    sig_all_zeros_event = 1'b0;
    crc4_multiframe_event = 1'b0;
    align_frame_event = 1'b0;
    rx_multiframe_event = 1'b0;
    one_second_event = 1'b0;
    timer_event = 1'b0;
    zero_count = 4'h0;

    idle_limit = mode_t1_i ? 10'(rlsb_pkg::CHAN_CYC_T1 - 1) : 10'(rlsb_pkg::CHAN_CYC_E1 - 1);
    sec_last = mode_t1_i ? 21'(SEC_EDGES_T1 - 1) : 21'(SEC_EDGES_E1 - 1);
    short_last = mode_t1_i ? 21'(SHORT_EDGES_T1 - 1) : 21'(SHORT_EDGES_E1 - 1);
    if (mode_t1_i)
      mf_last = esf_i ? 5'(rlsb_pkg::ESF_MF_FRAMES - 1) : 5'(rlsb_pkg::D4_MF_FRAMES - 1);
    else
      mf_last = 5'(rlsb_pkg::E1_MF_FRAMES - 1);
    // A marked frame is position 0 itself, not the one after it
    frame_pos = frame_i.mf_start ? 5'h00 : st_reg.frame_cnt;

    // Pin passes two flops; the third only feeds edge detection
    st_next.rclk_s1 = rclk_i;
    st_next.rclk_s2 = st_reg.rclk_s1;
    st_next.rclk_s3 = st_reg.rclk_s2;
    rclk_edge = st_reg.rclk_s2 ^ st_reg.rclk_s3;
    rclk_rise = st_reg.rclk_s2 & ~st_reg.rclk_s3;

    // Loss of receive clock: one channel time without a transition
    if (rclk_edge)
    begin
      st_next.idle_cnt = 10'h000;
      st_next.clock_loss = 1'b0;
    end
    else if (st_reg.idle_cnt >= idle_limit)
      st_next.clock_loss = 1'b1;
    else
      st_next.idle_cnt = st_reg.idle_cnt + 10'h001;

    // Timers run on recovered clock edges, so they stall with the line
    if (rclk_rise)
    begin
      if (st_reg.sec_cnt >= sec_last)
      begin
        st_next.sec_cnt = 21'h000000;
        one_second_event = 1'b1;
      end
      else
        st_next.sec_cnt = st_reg.sec_cnt + 21'h000001;
      if (st_reg.upd_cnt >= short_last)
        st_next.upd_cnt = 21'h000000;
      else
        st_next.upd_cnt = st_reg.upd_cnt + 21'h000001;
    end
    if (error_counter_config_i[rlsb_pkg::CFG_SHORT_INTERVAL])
      timer_event = rclk_rise && (st_reg.upd_cnt >= short_last);
    else
      timer_event = one_second_event;
    if (manual_latch_i)
      timer_event = 1'b1;

    // Frame position within the multiframe
    if (frame_i.strobe)
    begin
      if (frame_pos >= mf_last)
        st_next.frame_cnt = 5'h00;
      else
        st_next.frame_cnt = frame_pos + 5'h01;
      rx_multiframe_event = (frame_pos == mf_last);
      align_frame_event = !mode_t1_i && frame_pos[0];
    end

    // Free-running boundary keeps the event alive without CRC-4
    if (!mode_t1_i)
      crc4_multiframe_event = crc4_en_i ? crc4_mf_boundary_i : rx_multiframe_event;

    // CRC-4 codeword error ratio over a block of words
    if (crc_word_i.valid && !mode_t1_i)
    begin
      if (crc_word_i.err)
      begin
        st_next.crc_errs = st_reg.crc_errs + 10'h001;
        crc_resync_event = (st_reg.crc_errs == 10'(rlsb_pkg::CRC_ERR_LIMIT - 1));
      end
      if (st_reg.crc_words >= 10'(rlsb_pkg::CRC_WINDOW - 1))
      begin
        st_next.crc_words = 10'h000;
        st_next.crc_errs = 10'h000;
      end
      else
        st_next.crc_words = st_reg.crc_words + 10'h001;
    end

    if (cas_word_i.valid && !mode_t1_i)
    begin
      cas_resync_event = cas_word_i.err && st_reg.cas_err_prev;
      st_next.cas_err_prev = cas_word_i.err && !st_reg.cas_err_prev;
    end

    if (fas_word_i.valid && !mode_t1_i)
    begin
      if (!fas_word_i.err)
        st_next.fas_run = 2'h0;
      else if (st_reg.fas_run == 2'(rlsb_pkg::FAS_ERR_RUN - 1))
      begin
        fas_resync_event = 1'b1;
        st_next.fas_run = 2'h0;
      end
      else
        st_next.fas_run = st_reg.fas_run + 2'h1;
    end

    // Time slot 16 content checks, valid in CAS and CCS alike
    if (frame_i.strobe && !mode_t1_i)
    begin
      for (int b = 0; b < 8; b++)
        zero_count = zero_count + {3'h0, ~frame_i.ts16[b]};
      if (st_reg.ones_frames == 4'(rlsb_pkg::SIG_ONES_FRAMES - 1))
      begin
        sig_all_ones_event = ({2'h0, st_reg.ones_zeros} + zero_count)
                             < 4'(rlsb_pkg::SIG_ONES_MAX_ZEROS);
        st_next.ones_zeros = 2'h0;
      end
      else if (zero_count >= 4'(rlsb_pkg::SIG_ONES_MAX_ZEROS) ||
               ({2'h0, st_reg.ones_zeros} + zero_count) >= 4'(rlsb_pkg::SIG_ONES_MAX_ZEROS))
        st_next.ones_zeros = 2'(rlsb_pkg::SIG_ONES_MAX_ZEROS);
      else
        st_next.ones_zeros = st_reg.ones_zeros + zero_count[1:0];
      st_next.ones_frames = st_reg.ones_frames + 4'h1;

      if (frame_pos == 5'h00)
        st_next.zeros_all = (frame_i.ts16 == 8'h00);
      else
        st_next.zeros_all = st_reg.zeros_all && (frame_i.ts16 == 8'h00);
      sig_all_zeros_event = (frame_pos == mf_last) && st_reg.zeros_all
                            && (frame_i.ts16 == 8'h00);

      // Distant alarm needs the bit in two multiframes running
      if (frame_pos == 5'h00)
      begin
        st_next.dma_prev = frame_i.ts16[rlsb_pkg::DMA_BIT];
        st_next.dma_alarm = frame_i.ts16[rlsb_pkg::DMA_BIT] && st_reg.dma_prev;
      end
    end

    st_next.cond_prev = cond_i;

    // Read data is registered; the read clears the addressed byte, except the second register in T1 mode
    st_next.rvalid = rd_i;
    if (rd_i)
    begin
      unique case (addr_i)
        rlsb_pkg::RLS_TWO_ADDR: st_next.rdata = mode_t1_i ? 8'h00 : lat_two;
        rlsb_pkg::RLS_THREE_ADDR: st_next.rdata = lat_three;
        rlsb_pkg::RLS_FOUR_ADDR: st_next.rdata = lat_four;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  // Second register, E1 layout only
  always_comb
  begin
    set_two = 8'h00;
    set_two[rlsb_pkg::B2_CRC_RESYNC] = crc_resync_event;
    set_two[rlsb_pkg::B2_CAS_RESYNC] = cas_resync_event;
    set_two[rlsb_pkg::B2_FAS_RESYNC] = fas_resync_event;
    set_two[rlsb_pkg::B2_SIG_ONES] = sig_all_ones_event;
    set_two[rlsb_pkg::B2_SIG_ZEROS] = sig_all_zeros_event;
    set_two[rlsb_pkg::B2_CRC4_MF] = crc4_multiframe_event;
    set_two[rlsb_pkg::B2_ALIGN] = align_frame_event;
  end

  // Third register, layout chosen by line mode
  always_comb
  begin
    set_three = 8'h00;
    set_three[rlsb_pkg::B3_CLK_DETECT] = st_next.clock_loss & ~st_reg.clock_loss;
    set_three[rlsb_pkg::B3_CLK_CLEAR] = ~st_next.clock_loss & st_reg.clock_loss;
    if (mode_t1_i)
    begin
      set_three[rlsb_pkg::B3_SPARE_DETECT] = cond_i.spare & ~st_reg.cond_prev.spare;
      set_three[rlsb_pkg::B3_SPARE_CLEAR] = ~cond_i.spare & st_reg.cond_prev.spare;
      set_three[rlsb_pkg::B3_LOOPDN_DETECT] = cond_i.loopdown & ~st_reg.cond_prev.loopdown;
      set_three[rlsb_pkg::B3_LOOPDN_CLEAR] = ~cond_i.loopdown & st_reg.cond_prev.loopdown;
      set_three[rlsb_pkg::B3_LOOPUP_DETECT] = cond_i.loopup & ~st_reg.cond_prev.loopup;
      set_three[rlsb_pkg::B3_LOOPUP_CLEAR] = ~cond_i.loopup & st_reg.cond_prev.loopup;
    end
    else
    begin
      set_three[rlsb_pkg::B3_V52_DETECT] = cond_i.v52 & ~st_reg.cond_prev.v52;
      set_three[rlsb_pkg::B3_V52_CLEAR] = ~cond_i.v52 & st_reg.cond_prev.v52;
      set_three[rlsb_pkg::B3_DMA_DETECT] = st_next.dma_alarm & ~st_reg.dma_alarm;
      set_three[rlsb_pkg::B3_DMA_CLEAR] = ~st_next.dma_alarm & st_reg.dma_alarm;
    end
  end

  // Fourth register
  always_comb
  begin
    set_four = 8'h00;
    set_four[rlsb_pkg::B4_FULL] = elastic_full_i;
    set_four[rlsb_pkg::B4_EMPTY] = elastic_empty_i;
    set_four[rlsb_pkg::B4_SLIP] = elastic_full_i | elastic_empty_i;
    set_four[rlsb_pkg::B4_SIG_CHANGE] = |(sig_changed_i & sig_change_enable_i);
    set_four[rlsb_pkg::B4_ONE_SEC] = one_second_event;
    set_four[rlsb_pkg::B4_TIMER] = timer_event;
    set_four[rlsb_pkg::B4_MF] = rx_multiframe_event;
  end

  assign clr_two = rd_i && (addr_i == rlsb_pkg::RLS_TWO_ADDR) && !mode_t1_i;
  assign clr_three = rd_i && (addr_i == rlsb_pkg::RLS_THREE_ADDR);
  assign clr_four = rd_i && (addr_i == rlsb_pkg::RLS_FOUR_ADDR);

  rlsb_latch_byte u_two (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .set_i(set_two),
    .clear_i(clr_two),
    .bits_o(lat_two)
  );

  rlsb_latch_byte u_three (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .set_i(set_three),
    .clear_i(clr_three),
    .bits_o(lat_three)
  );

  rlsb_latch_byte u_four (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .set_i(set_four),
    .clear_i(clr_four),
    .bits_o(lat_four)
  );

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else if (ce_i)
      st_reg <= st_next;
  end

  assign rdata_o = st_reg.rdata;
  assign rvalid_o = st_reg.rvalid;
  assign rx_clock_loss_o = st_reg.clock_loss;
  // Only the low nibble of the second register may request service
  assign int_pending_o = (!mode_t1_i && |(lat_two & rlsb_pkg::RLS_TWO_INT_MASK))
                         || |lat_three || |lat_four;

endmodule : rlsb_status_bank

//--- bench/rlsb_line_model.sv
`timescale 1ns/1ps
module rlsb_line_model (
  // Control
  input wire logic run_i,
  // Recovered receive clock
  output logic rclk_o
);
  // Odd start offset keeps line clock edges clear of system clock edges, at a fixed phase
  initial
  begin
    rclk_o = 1'b0;
    #37;
    forever
    begin
      #80;
      // Stands still while stopped, so the loss detector sees no edges
      if (run_i)
        rclk_o = ~rclk_o;
    end
  end
endmodule : rlsb_line_model

//--- bench/rlsb_status_bank_props.sv
`timescale 1ns/1ps
module rlsb_status_bank_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Watched inputs
  input wire logic mode_t1_i,
  input wire logic rclk_i,
  input wire logic [31:0] sig_change_enable_i,
  input wire logic [31:0] sig_changed_i,
  input wire logic elastic_full_i,
  input wire logic elastic_empty_i,
  input wire logic manual_latch_i,
  input wire logic rd_i,
  input wire logic [rlsb_pkg::ADDR_W-1:0] addr_i,
  // Watched outputs
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic rx_clock_loss_o,
  input wire logic int_pending_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  logic rd4;
  logic mapped;
  assign rd4 = ce_i && rd_i && (addr_i == rlsb_pkg::RLS_FOUR_ADDR);
  assign mapped = addr_i inside {rlsb_pkg::RLS_TWO_ADDR, rlsb_pkg::RLS_THREE_ADDR,
    rlsb_pkg::RLS_FOUR_ADDR};
  property p_answer;
    ce_i && rd_i |=> rvalid_o;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_no_answer;
    !(ce_i && rd_i) |=> !rvalid_o;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("answer without read");
  property p_unmapped;
    ce_i && rd_i && !mapped |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_t1_two;
    ce_i && rd_i && mode_t1_i && addr_i == rlsb_pkg::RLS_TWO_ADDR |=> rdata_o == 8'h00;
  endproperty
  a_t1_two: assert property (p_t1_two) else $error("E1 layout shown in T1");
  property p_full;
    ce_i && elastic_full_i ##1 !rd4 ##1 rd4 |=> rdata_o[7] && rdata_o[5];
  endproperty
  a_full: assert property (p_full) else $error("full slip not latched");
  property p_empty;
    ce_i && elastic_empty_i ##1 !rd4 ##1 rd4 |=> rdata_o[6] && rdata_o[5];
  endproperty
  a_empty: assert property (p_empty) else $error("empty slip not latched");
  property p_sig;
    ce_i && (sig_changed_i & sig_change_enable_i) != 32'h0 ##1 !rd4 ##1 rd4 |=> rdata_o[3];
  endproperty
  a_sig: assert property (p_sig) else $error("signalling change lost");
  property p_manual;
    ce_i && manual_latch_i ##1 !rd4 ##1 rd4 |=> rdata_o[1];
  endproperty
  a_manual: assert property (p_manual) else $error("manual latch lost");
  property p_reread;
    rd4 && !elastic_full_i && !elastic_empty_i ##1 (!elastic_full_i && !elastic_empty_i) [*2]
      ##1 rd4
      |=> rdata_o[7:5] == 3'b000;
  endproperty
  a_reread: assert property (p_reread) else $error("read did not clear");
  property p_int;
    ce_i && elastic_full_i |=> int_pending_o;
  endproperty
  a_int: assert property (p_int) else $error("no interrupt request");
  property p_clk;
    rclk_i != $past(rclk_i) |-> ##[1:6] !rx_clock_loss_o;
  endproperty
  a_clk: assert property (p_clk) else $error("clock loss with clock running");
endmodule : rlsb_status_bank_props

bind rlsb_status_bank rlsb_status_bank_props i_rlsb_status_bank_props (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .mode_t1_i(mode_t1_i),
  .rclk_i(rclk_i), .sig_change_enable_i(sig_change_enable_i),
  .sig_changed_i(sig_changed_i), .elastic_full_i(elastic_full_i),
  .elastic_empty_i(elastic_empty_i), .manual_latch_i(manual_latch_i), .rd_i(rd_i),
  .addr_i(addr_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .rx_clock_loss_o(rx_clock_loss_o), .int_pending_o(int_pending_o));

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock_i, rst_n_i, ce_i, mode_t1_i, esf_i, crc4_en_i, rclk_i, run;
  logic crc4_mf_boundary_i, elastic_full_i, elastic_empty_i, manual_latch_i, rd_i;
  logic [7:0] error_counter_config_i, rdata_o, got;
  logic [31:0] sig_change_enable_i, sig_changed_i;
  logic [rlsb_pkg::ADDR_W-1:0] addr_i;
  rlsb_pkg::rlsb_frame_t frame_i;
  rlsb_pkg::rlsb_word_t crc_word_i, cas_word_i, fas_word_i;
  rlsb_pkg::rlsb_cond_t cond_i;
  logic rvalid_o, rx_clock_loss_o, int_pending_o;
  int errors, samples_checked;
  // Short timer counts keep the run brief
  rlsb_status_bank #(.SEC_EDGES_T1(20), .SEC_EDGES_E1(20), .SHORT_EDGES_T1(6),
    .SHORT_EDGES_E1(6)) i_rlsb_status_bank (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .mode_t1_i(mode_t1_i),
    .esf_i(esf_i), .crc4_en_i(crc4_en_i), .error_counter_config_i(error_counter_config_i),
    .sig_change_enable_i(sig_change_enable_i), .rclk_i(rclk_i), .frame_i(frame_i),
    .crc_word_i(crc_word_i), .cas_word_i(cas_word_i), .fas_word_i(fas_word_i),
    .crc4_mf_boundary_i(crc4_mf_boundary_i), .cond_i(cond_i),
    .sig_changed_i(sig_changed_i), .elastic_full_i(elastic_full_i),
    .elastic_empty_i(elastic_empty_i), .manual_latch_i(manual_latch_i), .rd_i(rd_i),
    .addr_i(addr_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .rx_clock_loss_o(rx_clock_loss_o), .int_pending_o(int_pending_o));
  rlsb_line_model i_rlsb_line_model (.run_i(run), .rclk_o(rclk_i));

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task automatic check8(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m,
    input string what);
    samples_checked++;
    if ((g & m) !== (e & m))
    begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : check8

  task automatic expect_reg(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m,
    input string what);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    check8({7'h00, rvalid_o}, 8'h01, 8'hFF, "read answer");
    check8(rdata_o, e, m, what);
    // Return on a rising edge so callers drive there
    @(posedge clock_i);
  endtask : expect_reg

  task automatic events(input logic [3:0] ev);
    @(posedge clock_i);
    {elastic_full_i, elastic_empty_i, manual_latch_i, crc4_mf_boundary_i} <= ev;
    @(posedge clock_i);
    {elastic_full_i, elastic_empty_i, manual_latch_i, crc4_mf_boundary_i} <= 4'h0;
  endtask : events

  task automatic words(input logic [2:0] v, input logic [2:0] e);
    @(posedge clock_i);
    crc_word_i <= {v[2], e[2]};
    cas_word_i <= {v[1], e[1]};
    fas_word_i <= {v[0], e[0]};
    @(posedge clock_i);
    {crc_word_i, cas_word_i, fas_word_i} <= 6'h00;
  endtask : words

  // One multiframe of 16 frames, first one marked as frame 0
  task automatic frames(input logic [7:0] ts, input logic [7:0] exp_two);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clock_i);
      frame_i <= {1'b1, i == 0, ts};
      @(posedge clock_i);
      frame_i <= '0;
    end
    expect_reg(12'h091, exp_two, 8'h0F, "frame events");
  endtask : frames

  task automatic t_reset();
    expect_reg(12'h091, 8'h00, 8'hFF, "reset two");
    expect_reg(12'h092, 8'h00, 8'hFF, "reset three");
    expect_reg(12'h093, 8'h00, 8'hFF, "reset four");
    expect_reg(12'h0A0, 8'h00, 8'hFF, "unmapped");
    $display("test reset done");
  endtask : t_reset

  task automatic t_frames();
    frames(8'h00, 8'h07);
    frames(8'hFF, 8'h0B);
    expect_reg(12'h092, 8'h00, 8'h11, "one alarm mf");
    frames(8'hFF, 8'h0B);
    expect_reg(12'h092, 8'h01, 8'h11, "alarm detect");
    frames(8'h00, 8'h07);
    expect_reg(12'h092, 8'h10, 8'h11, "alarm clear");
    $display("test frames done");
  endtask : t_frames

  task automatic t_words();
    repeat (914) words(3'b100, 3'b100);
    expect_reg(12'h091, 8'h00, 8'h40, "crc 914");
    words(3'b100, 3'b100);
    expect_reg(12'h091, 8'h40, 8'h40, "crc 915");
    words(3'b011, 3'b011);
    words(3'b011, 3'b001);
    words(3'b011, 3'b000);
    expect_reg(12'h091, 8'h00, 8'h30, "broken runs");
    words(3'b011, 3'b011);
    words(3'b011, 3'b011);
    words(3'b001, 3'b001);
    expect_reg(12'h091, 8'h30, 8'h30, "resync runs");
    $display("test words done");
  endtask : t_words

  task automatic t_cond();
    @(posedge clock_i);
    mode_t1_i <= 1'b1;
    cond_i <= 4'b1110;
    expect_reg(12'h092, 8'h07, 8'h77, "t1 codes on");
    cond_i <= 4'b0000;
    expect_reg(12'h092, 8'h70, 8'h77, "t1 codes off");
    expect_reg(12'h091, 8'h00, 8'hFF, "t1 two");
    mode_t1_i <= 1'b0;
    cond_i <= 4'b1001;
    expect_reg(12'h092, 8'h02, 8'h66, "e1 link on");
    cond_i <= 4'b0000;
    expect_reg(12'h092, 8'h20, 8'h66, "e1 link off");
    $display("test codes done");
  endtask : t_cond

  task automatic t_clock();
    run <= 1'b0;
    repeat (600) @(posedge clock_i);
    @(negedge clock_i);
    check8({7'h00, rx_clock_loss_o}, 8'h01, 8'h01, "loss");
    expect_reg(12'h092, 8'h08, 8'h88, "loss detect");
    run <= 1'b1;
    repeat (40) @(posedge clock_i);
    @(negedge clock_i);
    check8({7'h00, rx_clock_loss_o}, 8'h00, 8'h01, "loss gone");
    expect_reg(12'h092, 8'h80, 8'h88, "loss clear");
    $display("test clock done");
  endtask : t_clock

  task automatic t_events();
    events(4'b1000);
    expect_reg(12'h093, 8'hA0, 8'hE8, "full");
    events(4'b0100);
    expect_reg(12'h093, 8'h60, 8'hE8, "empty");
    sig_change_enable_i <= 32'h0000_0008;
    sig_changed_i <= 32'h0000_0020;
    @(posedge clock_i);
    sig_changed_i <= 32'h0;
    expect_reg(12'h093, 8'h00, 8'h08, "masked change");
    sig_changed_i <= 32'h0000_0008;
    @(posedge clock_i);
    sig_changed_i <= 32'h0;
    expect_reg(12'h093, 8'h08, 8'h08, "enabled change");
    expect_reg(12'h093, 8'h00, 8'hE8, "cleared by read");
    events(4'b0010);
    expect_reg(12'h093, 8'h02, 8'h02, "manual latch");
    // Events seen while the enable is low are lost
    ce_i <= 1'b0;
    events(4'b1000);
    ce_i <= 1'b1;
    expect_reg(12'h093, 8'h00, 8'hA0, "frozen by enable");
    crc4_en_i <= 1'b1;
    events(4'b0001);
    expect_reg(12'h091, 8'h02, 8'h02, "crc4 boundary");
    $display("test events done");
  endtask : t_events

  task automatic t_t1_mf();
    mode_t1_i <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clock_i);
      frame_i <= {1'b1, i == 0, 8'hFF};
      @(posedge clock_i);
      frame_i <= '0;
      if (i == 10)
        expect_reg(12'h093, 8'h00, 8'h01, "d4 early");
    end
    expect_reg(12'h093, 8'h01, 8'h01, "d4 boundary");
    mode_t1_i <= 1'b0;
    $display("test t1 multiframe done");
  endtask : t_t1_mf

  task automatic t_timers();
    error_counter_config_i <= 8'h01;
    expect_reg(12'h093, 8'h00, 8'h00, "flush");
    repeat (150) @(posedge clock_i);
    expect_reg(12'h093, 8'h02, 8'h02, "short timer");
    error_counter_config_i <= 8'h00;
    repeat (400) @(posedge clock_i);
    expect_reg(12'h093, 8'h04, 8'h04, "one second");
    $display("test timers done");
  endtask : t_timers

  initial
  begin
    #200us;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end

  initial
  begin
    errors = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    run = 1'b1;
    {mode_t1_i, esf_i, crc4_en_i, crc4_mf_boundary_i} = 4'h0;
    {elastic_full_i, elastic_empty_i, manual_latch_i, rd_i} = 4'h0;
    error_counter_config_i = 8'h00;
    sig_change_enable_i = 32'h0;
    sig_changed_i = 32'h0;
    addr_i = '0;
    frame_i = '0;
    {crc_word_i, cas_word_i, fas_word_i} = 6'h00;
    cond_i = '0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_frames();
    t_words();
    t_cond();
    t_clock();
    t_events();
    t_timers();
    t_t1_mf();
    results();
  end
endmodule : tb_top
